// [src/ecc_pkg.sv]
package ecc_pkg;

  // register indices of the capability space
  localparam logic [11:0] BASIC_CAP_IDX      = 12'h480;
  localparam logic [11:0] PIN_CAP_IDX        = 12'h481;
  localparam logic [11:0] PRIMARY_CAP_IDX    = 12'h482;
  localparam logic [11:0] SECONDARY_CAP_IDX  = 12'h48B;
  localparam logic [11:0] TRUE_PIN_CAP_IDX   = 12'h48D;
  localparam logic [11:0] TRUE_PRI_CAP_IDX   = 12'h48E;
  localparam logic [11:0] TERTIARY_CAP_IDX   = 12'h492;

  // field positions
  localparam int TRUE_FLEX_BIT      = 55;
  localparam int ACT_SECONDARY_BIT  = 31;
  localparam int ACT_TERTIARY_BIT   = 17;
  localparam int ALLOW1_BASE        = 32;

  // fixed-one class masks for the pin and primary two-half registers
  localparam logic [31:0] PIN_FIXED_ONE_MASK = 32'h0000_0016;
  localparam logic [31:0] PRI_FIXED_ONE_MASK = 32'h0401_E172;

  // check result latency in cycles after the request
  localparam int CHECK_LATENCY = 2;

endpackage

// [src/ecc_word_check.sv]
// one two-half control word against its allowed-0 / allowed-1 map
module ecc_word_check
  import ecc_pkg::*;
(
  input  wire logic [63:0] caps_in,
  input  wire logic [31:0] fixed_mask_in,
  input  wire logic        strict_fixed_in,
  input  wire logic [31:0] ctrl_in,
  output logic             bad_out
);

  logic [31:0] must_be_one;

  // fixed-one class forced to 1 only in strict mode
  always_comb begin
    must_be_one = caps_in[31:0] |
                  (strict_fixed_in ? fixed_mask_in : 32'h0000_0000);
    bad_out = (|(must_be_one & ~ctrl_in)) |
              (|(ctrl_in & ~caps_in[63:32]));
  end

endmodule

// [src/ecc_top.sv]
module ecc_top
  import ecc_pkg::*;
#(
  parameter logic        VIRT_SUPPORTED   = 1'b1,
  parameter logic [63:0] BASIC_CAPS       = 64'h0080_0000_0000_0001,
  parameter logic [63:0] PIN_CAPS_RAW     = 64'h0000_00FF_0000_0016,
  parameter logic [63:0] PRI_CAPS_RAW     = 64'hFFFE_FFFF_0401_E172,
  parameter logic [63:0] TRUE_PIN_CAPS    = 64'h0000_00FF_0000_0000,
  parameter logic [63:0] TRUE_PRI_CAPS    = 64'hFFFE_FFFF_0000_0000,
  parameter logic [63:0] SECONDARY_CAPS   = 64'h00FF_FFFF_0000_0000,
  parameter logic [63:0] TERTIARY_CAPS    = 64'h0000_0000_0000_00FF
)(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // capability register port
  input  wire logic        rd_en_in,
  input  wire logic        wr_en_in,
  input  wire logic [11:0] reg_idx_in,
  output logic [63:0]      rd_data_out,
  output logic             rd_valid_out,
  output logic             gp_fault_out,
  // guest entry check port
  input  wire logic        entry_req_in,
  input  wire logic [31:0] pin_ctrl_in,
  input  wire logic [31:0] pri_ctrl_in,
  input  wire logic [31:0] sec_ctrl_in,
  input  wire logic [63:0] ter_ctrl_in,
  output logic             entry_done_out,
  output logic             entry_fail_out
);

  ////////////////////////////////////////////////////////////////////////////
  // effective capability values

  logic        true_flex;
  logic [63:0] basic_caps;
  logic [63:0] pin_caps;
  logic [63:0] pri_caps;
  logic [63:0] sec_caps;
  logic [63:0] ter_caps;
  logic        sec_exists;
  logic        ter_exists;

  // flag only claims flexibility if some fixed-one control may really clear
  assign true_flex = BASIC_CAPS[TRUE_FLEX_BIT] &
    ((|(PIN_FIXED_ONE_MASK & ~TRUE_PIN_CAPS[31:0])) |
     (|(PRI_FIXED_ONE_MASK & ~TRUE_PRI_CAPS[31:0])));
  always_comb begin
    basic_caps = BASIC_CAPS;
    basic_caps[TRUE_FLEX_BIT] = true_flex;
  end
  assign pin_caps = PIN_CAPS_RAW |
                    {32'h0000_0000, PIN_FIXED_ONE_MASK};
  assign pri_caps = PRI_CAPS_RAW |
                    {32'h0000_0000, PRI_FIXED_ONE_MASK};
  // reserved secondary controls never get a 1-setting, low half zero
  assign sec_caps = {SECONDARY_CAPS[63:32], 32'h0000_0000};
  assign ter_caps = TERTIARY_CAPS;
  assign sec_exists = pri_caps[ALLOW1_BASE + ACT_SECONDARY_BIT];
  assign ter_exists = pri_caps[ALLOW1_BASE + ACT_TERTIARY_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // register read decode

  logic [63:0] dec_data;
  logic        dec_hit;

  always_comb begin
    dec_data = 64'h0000_0000_0000_0000;
    dec_hit  = 1'b0;
    unique case (reg_idx_in)
      BASIC_CAP_IDX: begin
        dec_data = basic_caps;
        dec_hit  = 1'b1;
      end
      PIN_CAP_IDX: begin
        dec_data = pin_caps;
        dec_hit  = 1'b1;
      end
      PRIMARY_CAP_IDX: begin
        dec_data = pri_caps;
        dec_hit  = 1'b1;
      end
      SECONDARY_CAP_IDX: begin
        dec_data = sec_caps;
        dec_hit  = sec_exists;
      end
      TRUE_PIN_CAP_IDX: begin
        dec_data = TRUE_PIN_CAPS;
        dec_hit  = true_flex;
      end
      TRUE_PRI_CAP_IDX: begin
        dec_data = TRUE_PRI_CAPS;
        dec_hit  = true_flex;
      end
      TERTIARY_CAP_IDX: begin
        dec_data = ter_caps;
        dec_hit  = ter_exists;
      end
      default: begin
        dec_data = 64'h0000_0000_0000_0000;
        dec_hit  = 1'b0;
      end
    endcase
    if (!VIRT_SUPPORTED) begin
      dec_hit = 1'b0;
    end
  end

  // read answer one cycle after the request; any write faults
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out  <= 64'h0000_0000_0000_0000;
      rd_valid_out <= 1'b0;
      gp_fault_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in & ~wr_en_in & dec_hit;
      rd_data_out  <= (rd_en_in & ~wr_en_in & dec_hit) ?
                      dec_data : 64'h0000_0000_0000_0000;
      gp_fault_out <= wr_en_in |
                      (rd_en_in & ~dec_hit);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // guest entry check

  logic        pin_bad;
  logic        pri_bad;
  logic        sec_bad;
  logic        ter_bad;
  logic [63:0] pin_sel;
  logic [63:0] pri_sel;

  // flexible mode uses the alternate maps, no fixed-one exceptions
  assign pin_sel = true_flex ? TRUE_PIN_CAPS : pin_caps;
  assign pri_sel = true_flex ? TRUE_PRI_CAPS : pri_caps;

  ecc_word_check u_pin_chk (
    .caps_in         (pin_sel),
    .fixed_mask_in   (PIN_FIXED_ONE_MASK),
    .strict_fixed_in (~true_flex),
    .ctrl_in         (pin_ctrl_in),
    .bad_out         (pin_bad)
  );

  ecc_word_check u_pri_chk (
    .caps_in         (pri_sel),
    .fixed_mask_in   (PRI_FIXED_ONE_MASK),
    .strict_fixed_in (~true_flex),
    .ctrl_in         (pri_ctrl_in),
    .bad_out         (pri_bad)
  );

  // secondary and tertiary are judged only under their activate control
  assign sec_bad = pri_ctrl_in[ACT_SECONDARY_BIT] &
                   (|(sec_ctrl_in & ~sec_caps[63:32]));
  assign ter_bad = pri_ctrl_in[ACT_TERTIARY_BIT] &
                   (|(ter_ctrl_in & ~ter_caps));

  logic stage_q;
  logic fail_q;

  // registered so all words settle together before the verdict
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage_q        <= 1'b0;
      fail_q         <= 1'b0;
      entry_done_out <= 1'b0;
      entry_fail_out <= 1'b0;
    end else begin
      stage_q        <= entry_req_in;
      fail_q         <= entry_req_in &
                        (pin_bad | pri_bad | sec_bad | ter_bad);
      entry_done_out <= stage_q;
      entry_fail_out <= stage_q & fail_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_fixed_pin_read;
    @(posedge core_clk_in) disable iff (rst_in)
    (rd_en_in && !wr_en_in && reg_idx_in == PIN_CAP_IDX && VIRT_SUPPORTED)
      |=> (rd_valid_out && (rd_data_out[4:1] & 4'hB) == 4'hB);
  endproperty
  a_fixed_pin_read: assert property (p_fixed_pin_read)
    else $error("pin fixed-one bits not read as one");

  property p_fixed_pri_read;
    @(posedge core_clk_in) disable iff (rst_in)
    (rd_en_in && !wr_en_in && reg_idx_in == PRIMARY_CAP_IDX && VIRT_SUPPORTED)
      |=> ((rd_data_out[31:0] & PRI_FIXED_ONE_MASK) == PRI_FIXED_ONE_MASK);
  endproperty
  a_fixed_pri_read: assert property (p_fixed_pri_read)
    else $error("primary fixed-one bits not read as one");

  property p_write_faults;
    @(posedge core_clk_in) disable iff (rst_in)
    wr_en_in |=> (gp_fault_out && !rd_valid_out);
  endproperty
  a_write_faults: assert property (p_write_faults)
    else $error("write did not fault");

  property p_sec_low_zero;
    @(posedge core_clk_in) disable iff (rst_in)
    (rd_en_in && !wr_en_in && reg_idx_in == SECONDARY_CAP_IDX)
      |=> (rd_data_out[31:0] == 32'h0000_0000);
  endproperty
  a_sec_low_zero: assert property (p_sec_low_zero)
    else $error("secondary low half not zero");

  property p_true_absent;
    @(posedge core_clk_in) disable iff (rst_in)
    (rd_en_in && !wr_en_in && !true_flex &&
     (reg_idx_in == TRUE_PIN_CAP_IDX || reg_idx_in == TRUE_PRI_CAP_IDX))
      |=> (gp_fault_out && !rd_valid_out);
  endproperty
  a_true_absent: assert property (p_true_absent)
    else $error("alternate register readable without flag");

  property p_sec_exists;
    @(posedge core_clk_in) disable iff (rst_in)
    (rd_en_in && !wr_en_in && reg_idx_in == SECONDARY_CAP_IDX)
      |=> (rd_valid_out == (sec_exists && VIRT_SUPPORTED));
  endproperty
  a_sec_exists: assert property (p_sec_exists)
    else $error("secondary register presence wrong");

  property p_ter_exists;
    @(posedge core_clk_in) disable iff (rst_in)
    (rd_en_in && !wr_en_in && reg_idx_in == TERTIARY_CAP_IDX)
      |=> (rd_valid_out == (ter_exists && VIRT_SUPPORTED));
  endproperty
  a_ter_exists: assert property (p_ter_exists)
    else $error("tertiary register presence wrong");

  property p_strict_pin_fail;
    @(posedge core_clk_in) disable iff (rst_in)
    (entry_req_in && !true_flex && ((pin_ctrl_in & PIN_FIXED_ONE_MASK)
      != PIN_FIXED_ONE_MASK)) |-> ##2 (entry_done_out && entry_fail_out);
  endproperty
  a_strict_pin_fail: assert property (p_strict_pin_fail)
    else $error("fixed-one pin control zero not rejected");

  property p_sec_gate;
    @(posedge core_clk_in) disable iff (rst_in)
    (entry_req_in && !pri_ctrl_in[ACT_SECONDARY_BIT] && !pin_bad && !pri_bad
     && !ter_bad) |-> ##2 (entry_done_out && !entry_fail_out);
  endproperty
  a_sec_gate: assert property (p_sec_gate)
    else $error("secondary checked while inactive");

  property p_ter_fail;
    @(posedge core_clk_in) disable iff (rst_in)
    (entry_req_in && pri_ctrl_in[ACT_TERTIARY_BIT] &&
     |(ter_ctrl_in & ~ter_caps)) |-> ##2 entry_fail_out;
  endproperty
  a_ter_fail: assert property (p_ter_fail)
    else $error("tertiary violation not rejected");

  property p_done_pulse;
    @(posedge core_clk_in) disable iff (rst_in)
    entry_fail_out |-> entry_done_out;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("fail without done");

  c_entry_fail: cover property (@(posedge core_clk_in) disable iff (rst_in)
    entry_fail_out);
  c_entry_pass: cover property (@(posedge core_clk_in) disable iff (rst_in)
    entry_done_out && !entry_fail_out);
  c_read_ok: cover property (@(posedge core_clk_in) disable iff (rst_in)
    rd_valid_out);
  c_fault: cover property (@(posedge core_clk_in) disable iff (rst_in)
    gp_fault_out);

endmodule

// [tb/ecc_top_test.sv]
module ecc_top_test
  import ecc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst;
  logic        rd_en;
  logic        wr_en;
  logic [11:0] idx;
  logic        req;
  logic [31:0] pin;
  logic [31:0] pri;
  logic [31:0] sec;
  logic [63:0] ter;
  logic [63:0] rdat1;
  logic [63:0] rdat2;
  logic        rval1;
  logic        rval2;
  logic        flt1;
  logic        flt2;
  logic        done1;
  logic        done2;
  logic        fail1;
  logic        fail2;
  logic [63:0] rdat3;
  logic        rval3;
  logic        flt3;
  int          err_total;
  int          check_count;

  // base control word: every fixed-one primary control set
  localparam logic [31:0] PB = 32'h0401_E172;

  //////////////////////////////////////////////////////////////////////////
  // uut keeps the flexibility flag at 1, the second copy reads it as 0
  ecc_top #(.TRUE_PRI_CAPS(64'hFFFF_FFFF_0000_0000)) uut (
    .core_clk_in(clk), .rst_in(rst), .rd_en_in(rd_en), .wr_en_in(wr_en),
    .reg_idx_in(idx), .rd_data_out(rdat1), .rd_valid_out(rval1),
    .gp_fault_out(flt1), .entry_req_in(req), .pin_ctrl_in(pin),
    .pri_ctrl_in(pri), .sec_ctrl_in(sec), .ter_ctrl_in(ter),
    .entry_done_out(done1), .entry_fail_out(fail1));

  // raw maps with low halves cleared show the forced fixed-one bits
  ecc_top #(
    .BASIC_CAPS    (64'h0000_0000_0000_0001),
    .PIN_CAPS_RAW  (64'h0000_00FF_0000_0000),
    .PRI_CAPS_RAW  (64'hFFFF_FFFF_0000_0000),
    .SECONDARY_CAPS(64'h00FF_FFFF_0000_00FF)
  ) uut_strict (
    .core_clk_in(clk), .rst_in(rst), .rd_en_in(rd_en), .wr_en_in(wr_en),
    .reg_idx_in(idx), .rd_data_out(rdat2), .rd_valid_out(rval2),
    .gp_fault_out(flt2), .entry_req_in(req), .pin_ctrl_in(pin),
    .pri_ctrl_in(pri), .sec_ctrl_in(sec), .ter_ctrl_in(ter),
    .entry_done_out(done2), .entry_fail_out(fail2));

  // no virtualization support: every read and every write must fault
  ecc_top #(.VIRT_SUPPORTED(1'b0)) uut_novirt (
    .core_clk_in(clk), .rst_in(rst), .rd_en_in(rd_en), .wr_en_in(wr_en),
    .reg_idx_in(idx), .rd_data_out(rdat3), .rd_valid_out(rval3),
    .gp_fault_out(flt3), .entry_req_in(req), .pin_ctrl_in(pin),
    .pri_ctrl_in(pri), .sec_ctrl_in(sec), .ter_ctrl_in(ter),
    .entry_done_out(), .entry_fail_out());

  //////////////////////////////////////////////////////////////////////////
  // 50 MHz core clock
  always #10 clk = ~clk;

  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // one register access; an expected value of zero means a fault
  task automatic acc(input logic r, input logic w, input logic [11:0] ix,
                     input logic [63:0] x1, input logic [63:0] x2);
    @(posedge clk);
    rd_en <= r;
    wr_en <= w;
    idx   <= ix;
    @(posedge clk);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    #1;
    cmp(rdat1, x1);
    cmp(rval1, x1 != 64'h0);
    cmp(flt1, x1 == 64'h0);
    cmp(rdat2, x2);
    cmp(rval2, x2 != 64'h0);
    cmp(flt2, x2 == 64'h0);
    cmp(rdat3, 64'h0);
    cmp(rval3, 1'b0);
    cmp(flt3, r | w);
  endtask

  // one entry check; the verdict lands a fixed latency after the take edge
  task automatic ent(input logic [31:0] pn, input logic [31:0] pr,
                     input logic [31:0] sc, input logic [63:0] tr,
                     input logic f1, input logic f2);
    @(posedge clk);
    req <= 1'b1;
    pin <= pn;
    pri <= pr;
    sec <= sc;
    ter <= tr;
    @(posedge clk);
    req <= 1'b0;
    // the take edge is already behind us, so one edge less remains
    repeat (CHECK_LATENCY - 1) @(posedge clk);
    #1;
    cmp(done1, 1'b1);
    cmp(fail1, f1);
    cmp(done2, 1'b1);
    cmp(fail2, f2);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence: every wait is a fixed count, so no hang is possible
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    rd_en = 1'b0;
    wr_en = 1'b0;
    idx = 12'h000;
    req = 1'b0;
    pin = 32'h0;
    pri = 32'h0;
    sec = 32'h0;
    ter = 64'h0;
    err_total = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    acc(1, 0, 12'h480, 64'h0080_0000_0000_0001, 64'h1);
    acc(1, 0, 12'h481, 64'h0000_00FF_0000_0016,
        64'h0000_00FF_0000_0016);
    acc(1, 0, 12'h482, 64'hFFFE_FFFF_0401_E172,
        64'hFFFF_FFFF_0401_E172);
    acc(1, 0, 12'h48B, 64'h00FF_FFFF_0000_0000,
        64'h00FF_FFFF_0000_0000);
    acc(1, 0, 12'h48D, 64'h0000_00FF_0000_0000, 64'h0);
    acc(1, 0, 12'h48E, 64'hFFFF_FFFF_0000_0000, 64'h0);
    acc(1, 0, 12'h492, 64'hFF, 64'hFF);
    acc(1, 0, 12'h483, 64'h0, 64'h0);
    acc(0, 1, 12'h481, 64'h0, 64'h0);
    acc(1, 1, 12'h482, 64'h0, 64'h0);
    ent(32'h16, PB, 32'h0, 64'h0, 1'b0, 1'b0);
    ent(32'h14, PB, 32'h0, 64'h0, 1'b0, 1'b1);
    ent(32'h16, 32'h0400_E172, 32'h0, 64'h0, 1'b0, 1'b1);
    ent(32'h116, PB, 32'h0, 64'h0, 1'b1, 1'b1);
    ent(32'h16, PB | 32'h8000_0000, 32'h0100_0000, 64'h0,
        1'b1, 1'b1);
    ent(32'h16, PB, 32'h0100_0000, 64'h0, 1'b0, 1'b0);
    ent(32'h16, PB | 32'h8000_0000, 32'h0080_0000, 64'h0,
        1'b0, 1'b0);
    ent(32'h16, PB | 32'h0002_0000, 32'h0, 64'h100, 1'b1, 1'b1);
    ent(32'h16, PB, 32'h0, 64'h100, 1'b0, 1'b0);
    ent(32'h16, PB | 32'h0002_0000, 32'h0, 64'h80, 1'b0, 1'b0);
    finish_test();
  end

endmodule
